// ---- hw/tev_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module tev_master (
   input wire logic clk,
   input wire logic rst,
   tev_if.master bus,
   input wire logic start,
   input wire logic size_3u,
   input wire logic [7:0] xam,
   input wire logic [63:0] addr,
   input wire logic [8:0] beats,
   input wire logic [63:0] wdata,
   input wire logic wvalid,
   output logic wready,
   output logic busy,
   output logic done,
   output logic err
);

   tev_pkg::tev_mst_t state_q;
   logic [1:0] dtk_sync_q;
   logic ds_q;
   logic as_n_q;
   logic [5:0] am_q;
   logic [31:0] a_q;
   logic [63:0] d_q;
   logic [1:0] phase_q;
   logic [8:0] left_q;
   logic [3:0] gap_q;
   logic [7:0] wait_q;
   logic size_3u_q;
   logic [7:0] xam_q;
   logic [63:0] addr_q;
   logic [7:0] bcnt_q;
   logic done_q;
   logic err_q;
   logic [11:0] bytes;
   logic [11:0] offs;
   logic bad;
   logic acked;

   // ---------------------------------------------------------------
   // Acknowledge synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         dtk_sync_q <= 2'b00;
      else
         dtk_sync_q <= {dtk_sync_q[0], bus.dtack};
   end

   assign acked = (dtk_sync_q[1] == ds_q);

   // ---------------------------------------------------------------
   // Request checks
   // ---------------------------------------------------------------
   // Byte count and offset within the block that may not be crossed.
   always_comb
   begin
      bytes = size_3u ? {1'b0, beats, 2'b00} : {beats, 3'b000};
      offs = size_3u ? {2'b00, addr[9:0]} : {1'b0, addr[10:0]};
      bad = beats[0] || (beats > 9'(tev_pkg::MAX_BEATS)) ||
            ((xam != tev_pkg::XAM_A32) && (xam != tev_pkg::XAM_WIDE)) ||
            ((offs + bytes) > (size_3u ? tev_pkg::BLK_3U_BYTES : tev_pkg::BLK_6U_BYTES));
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= tev_pkg::M_IDLE;
         as_n_q <= 1'b1;
         ds_q <= 1'b0;
         am_q <= 6'h00;
         a_q <= 32'h0000_0000;
         d_q <= 64'h0000_0000_0000_0000;
         phase_q <= 2'h0;
         left_q <= 9'h000;
         gap_q <= 4'h0;
         wait_q <= 8'h00;
         size_3u_q <= 1'b0;
         xam_q <= 8'h00;
         addr_q <= 64'h0000_0000_0000_0000;
         bcnt_q <= 8'h00;
         done_q <= 1'b0;
         err_q <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         err_q <= 1'b0;
         if (gap_q != 4'h0)
            gap_q <= gap_q - 4'h1;
         case (state_q)
            tev_pkg::M_IDLE:
            begin
               if (start && bad)
                  err_q <= 1'b1;
               else if (start)
               begin
                  size_3u_q <= size_3u;
                  xam_q <= xam;
                  addr_q <= addr;
                  bcnt_q <= beats[8:1];
                  left_q <= beats;
                  as_n_q <= 1'b0;
                  am_q <= size_3u ? tev_pkg::AM_3U : tev_pkg::AM_6U;
                  // First phase: code on the low byte, address bits 63:40 on the rest for full-size wide, else zero.
                  a_q <= {(xam == tev_pkg::XAM_WIDE && !size_3u) ? addr[63:40] : 24'h000000,
                          xam};
                  phase_q <= 2'h0;
                  state_q <= tev_pkg::M_STRB;
               end
            end
            tev_pkg::M_STRB:
            begin
               if (gap_q == 4'h0)
               begin
                  ds_q <= ~ds_q;
                  gap_q <= tev_pkg::BEAT_CYC - 4'h1;
                  wait_q <= 8'h00;
                  state_q <= tev_pkg::M_WAIT;
               end
            end
            tev_pkg::M_WAIT:
            begin
               wait_q <= wait_q + 8'h01;
               if (acked && phase_q == 2'h0)
               begin
                  phase_q <= 2'h1;
                  a_q <= {8'h00, (xam_q == tev_pkg::XAM_WIDE) ? addr_q[39:32] : 8'h00,
                          bcnt_q, 8'h00};
                  state_q <= tev_pkg::M_STRB;
               end
               else if (acked && phase_q == 2'h1)
               begin
                  phase_q <= tev_pkg::LAST_PHASE;
                  a_q <= addr_q[31:0];
                  state_q <= tev_pkg::M_STRB;
               end
               else if (acked && phase_q == tev_pkg::LAST_PHASE)
               begin
                  phase_q <= 2'h3;
                  state_q <= (left_q == 9'h000) ? tev_pkg::M_END : tev_pkg::M_DATA;
               end
               else if (acked)
               begin
                  left_q <= left_q - 9'h001;
                  state_q <= (left_q == 9'h001) ? tev_pkg::M_END : tev_pkg::M_DATA;
               end
               else if (wait_q == tev_pkg::TIMEOUT_CYC)
               begin
                  err_q <= 1'b1;
                  as_n_q <= 1'b1;
                  // An abandoned cycle leaves the lines at zero, as after a normal end.
                  a_q <= 32'h0000_0000;
                  d_q <= 64'h0000_0000_0000_0000;
                  state_q <= tev_pkg::M_IDLE;
               end
            end
            tev_pkg::M_DATA:
            begin
               if (wvalid)
               begin
                  d_q <= size_3u_q ? {32'h0000_0000, wdata[31:0]} : wdata;
                  state_q <= tev_pkg::M_STRB;
               end
            end
            tev_pkg::M_END:
            begin
               as_n_q <= 1'b1;
               a_q <= 32'h0000_0000;
               d_q <= 64'h0000_0000_0000_0000;
               done_q <= 1'b1;
               state_q <= tev_pkg::M_IDLE;
            end
            default:
               state_q <= tev_pkg::M_IDLE;
         endcase
      end
   end

   assign wready = (state_q == tev_pkg::M_DATA);
   assign busy = (state_q != tev_pkg::M_IDLE);
   assign done = done_q;
   assign err = err_q;
   assign bus.as_n = as_n_q;
   assign bus.ds = ds_q;
   assign bus.am = am_q;
   assign bus.a = a_q;
   assign bus.d = d_q;

endmodule : tev_master
`default_nettype wire

// ---- hw/tev_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module tev_slave #(
   parameter bit EN_6U = 1'b1,
   parameter bit EN_3U = 1'b1
) (
   input wire logic clk,
   input wire logic rst,
   tev_if.slave bus,
   output logic hdr_valid,
   output logic hdr_3u,
   output logic hdr_wide,
   output logic [63:0] hdr_addr,
   output logic [8:0] hdr_beats,
   output logic hdr_open,
   output logic data_valid,
   output logic [63:0] data,
   output logic ended,
   output logic ignored
);

   tev_pkg::tev_slv_t state_q;
   logic [1:0] as_sync_q;
   logic [1:0] ds_sync_q;
   logic [5:0] am_s1_q;
   logic [5:0] am_s2_q;
   logic [31:0] a_s1_q;
   logic [31:0] a_s2_q;
   logic [63:0] d_s1_q;
   logic [63:0] d_s2_q;
   logic ds_seen_q;
   logic dtack_q;
   logic [1:0] phase_q;
   logic size_3u_q;
   logic wide_q;
   logic [63:0] addr_q;
   logic [7:0] bcnt_q;
   logic hdr_valid_q;
   logic data_valid_q;
   logic [63:0] data_q;
   logic ended_q;
   logic ignored_q;
   logic edge_seen;
   logic active;
   logic code_ok;
   logic is_6u;
   logic is_3u;

   // ---------------------------------------------------------------
   // Line synchronisers
   // ---------------------------------------------------------------
   // Strobes and the lines they qualify pass the same two stages, so
   // a strobe edge is seen together with the lines it was sent with.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         as_sync_q <= 2'b11;
         ds_sync_q <= 2'b00;
      end
      else
      begin
         as_sync_q <= {as_sync_q[0], bus.as_n};
         ds_sync_q <= {ds_sync_q[0], bus.ds};
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         am_s1_q <= 6'h00;
         am_s2_q <= 6'h00;
         a_s1_q <= 32'h0000_0000;
         a_s2_q <= 32'h0000_0000;
         d_s1_q <= 64'h0000_0000_0000_0000;
         d_s2_q <= 64'h0000_0000_0000_0000;
      end
      else
      begin
         am_s1_q <= bus.am;
         am_s2_q <= am_s1_q;
         a_s1_q <= bus.a;
         a_s2_q <= a_s1_q;
         d_s1_q <= bus.d;
         d_s2_q <= d_s1_q;
      end
   end

   assign active = ~as_sync_q[1];
   assign edge_seen = (ds_sync_q[1] != ds_seen_q);

   // ---------------------------------------------------------------
   // Transaction decode
   // ---------------------------------------------------------------
   always_comb
   begin
      is_6u = EN_6U && (am_s2_q == tev_pkg::AM_6U);
      is_3u = EN_3U && (am_s2_q == tev_pkg::AM_3U);
      // Code 02 means a 64-bit address on full size and 40-bit on small.
      code_ok = (is_6u || is_3u) &&
                ((a_s2_q[7:0] == tev_pkg::XAM_A32) ||
                 (a_s2_q[7:0] == tev_pkg::XAM_WIDE));
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= tev_pkg::S_IDLE;
         ds_seen_q <= 1'b0;
         dtack_q <= 1'b0;
         phase_q <= 2'h0;
         size_3u_q <= 1'b0;
         wide_q <= 1'b0;
         addr_q <= 64'h0000_0000_0000_0000;
         bcnt_q <= 8'h00;
      end
      else
      begin
         if (edge_seen)
            ds_seen_q <= ds_sync_q[1];
         case (state_q)
            tev_pkg::S_IDLE:
            begin
               phase_q <= 2'h0;
               if (active)
                  state_q <= tev_pkg::S_ADDR;
            end
            tev_pkg::S_ADDR:
            begin
               if (!active)
                  state_q <= tev_pkg::S_IDLE;
               else if (edge_seen && phase_q == 2'h0)
               begin
                  if (code_ok)
                  begin
                     size_3u_q <= is_3u;
                     wide_q <= (a_s2_q[7:0] == tev_pkg::XAM_WIDE);
                     // Top bits are only meaningful for the 64-bit mode.
                     addr_q[63:40] <= (is_6u && a_s2_q[7:0] == tev_pkg::XAM_WIDE) ?
                                      a_s2_q[31:8] : 24'h000000;
                     dtack_q <= ~dtack_q;
                     phase_q <= 2'h1;
                  end
                  else
                     state_q <= tev_pkg::S_IGN;
               end
               else if (edge_seen && phase_q == 2'h1)
               begin
                  bcnt_q <= a_s2_q[15:8];
                  addr_q[39:32] <= wide_q ? a_s2_q[23:16] : 8'h00;
                  dtack_q <= ~dtack_q;
                  phase_q <= tev_pkg::LAST_PHASE;
               end
               else if (edge_seen)
               begin
                  addr_q[31:0] <= a_s2_q;
                  dtack_q <= ~dtack_q;
                  state_q <= tev_pkg::S_DATA;
               end
            end
            tev_pkg::S_DATA:
            begin
               if (!active)
                  state_q <= tev_pkg::S_IDLE;
               else if (edge_seen)
                  dtack_q <= ~dtack_q;
            end
            tev_pkg::S_IGN:
            begin
               if (!active)
                  state_q <= tev_pkg::S_IDLE;
            end
            default:
               state_q <= tev_pkg::S_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // User-side outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         hdr_valid_q <= 1'b0;
         data_valid_q <= 1'b0;
         data_q <= 64'h0000_0000_0000_0000;
         ended_q <= 1'b0;
         ignored_q <= 1'b0;
      end
      else
      begin
         hdr_valid_q <= (state_q == tev_pkg::S_ADDR) && active && edge_seen &&
                        (phase_q == tev_pkg::LAST_PHASE);
         data_valid_q <= (state_q == tev_pkg::S_DATA) && active && edge_seen;
         if ((state_q == tev_pkg::S_DATA) && active && edge_seen)
            data_q <= size_3u_q ? {32'h0000_0000, d_s2_q[31:0]} : d_s2_q;
         ended_q <= (state_q == tev_pkg::S_DATA) && !active;
         ignored_q <= (state_q == tev_pkg::S_ADDR) && active && edge_seen &&
                      (phase_q == 2'h0) && !code_ok;
      end
   end

   assign hdr_valid = hdr_valid_q;
   assign hdr_3u = size_3u_q;
   assign hdr_wide = wide_q;
   assign hdr_addr = addr_q;
   // An unknown count reads as open with zero beats.
   assign hdr_open = (bcnt_q == tev_pkg::BCNT_UNKNOWN);
   assign hdr_beats = (bcnt_q > tev_pkg::BCNT_MAX) ? 9'h000 : {bcnt_q, 1'b0};
   assign data_valid = data_valid_q;
   assign data = data_q;
   assign ended = ended_q;
   assign ignored = ignored_q;
   assign bus.dtack = dtack_q;

endmodule : tev_slave
`default_nettype wire

// ---- include/tev_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface tev_if;
   // Address strobe, active low, held for the whole transaction.
   logic as_n;
   // Data strobe; every edge, rising or falling, is one phase or beat.
   logic ds;
   // Acknowledge; every edge answers one strobe edge.
   logic dtack;
   logic [5:0] am;
   // Address lines; bit 0 is the remapped long-word line.
   logic [31:0] a;
   logic [63:0] d;

   modport master (output as_n, output ds, output am, output a, output d, input dtack);
   modport slave (input as_n, input ds, input am, input a, input d, output dtack);
endinterface : tev_if
`default_nettype wire

// ---- include/tev_pkg.sv ----
`default_nettype none
package tev_pkg;

   // ---------------------------------------------------------------
   // Transaction codes
   // ---------------------------------------------------------------
   localparam logic [5:0] AM_6U = 6'h20;
   localparam logic [5:0] AM_3U = 6'h21;
   localparam logic [7:0] XAM_A32 = 8'h01;
   localparam logic [7:0] XAM_WIDE = 8'h02;
   localparam logic [7:0] BCNT_UNKNOWN = 8'hFF;
   localparam logic [7:0] BCNT_MAX = 8'h80;

   // ---------------------------------------------------------------
   // Field positions in the address phases
   // ---------------------------------------------------------------
   localparam int XAM_LSB = 0;
   localparam int BCNT_LSB = 8;
   localparam int HI_LSB = 16;

   // ---------------------------------------------------------------
   // Sizes and timing
   // ---------------------------------------------------------------
   localparam int MAX_BEATS = 256;
   localparam logic [11:0] BLK_6U_BYTES = 12'h800;
   localparam logic [11:0] BLK_3U_BYTES = 12'h400;
   localparam int CLK_NS = 8;
   localparam int BEAT_NS = 50;
   localparam logic [3:0] BEAT_CYC = 4'((BEAT_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] TIMEOUT_CYC = 8'hFF;
   localparam logic [1:0] LAST_PHASE = 2'h2;

   // ---------------------------------------------------------------
   // States
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      M_IDLE = 3'b000,
      M_STRB = 3'b001,
      M_WAIT = 3'b010,
      M_DATA = 3'b011,
      M_END = 3'b100
   } tev_mst_t;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_ADDR = 2'b01,
      S_DATA = 2'b10,
      S_IGN = 2'b11
   } tev_slv_t;

endpackage : tev_pkg
`default_nettype wire

// ---- verif/test_two_edge_vme_address_phase.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
   begin \
      num_checks++; \
      if ((g) !== (e)) \
      begin \
         num_errors++; \
         $display("wrong value at %0t ns: got %0h expected %0h", $time, (g), (e)); \
      end \
   end
module test_two_edge_vme_address_phase;
   logic clk;
   logic rst;
   logic start;
   logic size_3u;
   logic [7:0] xam;
   logic [63:0] addr;
   logic [8:0] beats;
   logic [63:0] wdata;
   logic wvalid;
   logic wready;
   logic done;
   logic err;
   logic busy;
   logic hv, h3, hw, ho, dv, en, ig, ig_b;
   logic hv_b, ho_b;
   logic [8:0] hb_b;
   logic [63:0] ha;
   logic [63:0] sdata;
   logic [8:0] hb;
   int num_errors = 0;
   int num_checks = 0;

   tev_if bus();
   tev_if bus_b();

   tev_master u_tev_master (.clk(clk), .rst(rst), .bus(bus), .start(start), .size_3u(size_3u),
      .xam(xam), .addr(addr), .beats(beats), .wdata(wdata), .wvalid(wvalid), .wready(wready),
      .busy(busy), .done(done), .err(err));
   tev_slave u_tev_slave (.clk(clk), .rst(rst), .bus(bus), .hdr_valid(hv), .hdr_3u(h3),
      .hdr_wide(hw), .hdr_addr(ha), .hdr_beats(hb), .hdr_open(ho), .data_valid(dv),
      .data(sdata), .ended(en), .ignored(ig));
   tev_slave #(.EN_3U(1'b0)) u_tev_slave_b (.clk(clk), .rst(rst), .bus(bus_b),
      .hdr_valid(hv_b), .hdr_3u(), .hdr_wide(), .hdr_addr(), .hdr_beats(hb_b),
      .hdr_open(ho_b), .data_valid(), .data(), .ended(), .ignored(ig_b));
   tev_asserts u_tev_asserts (.clk(clk), .rst(rst), .as_n(bus.as_n), .ds(bus.ds),
      .dtack(bus.dtack), .am(bus.am), .a(bus.a), .d(bus.d));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   function automatic logic [63:0] pat(int i, logic s3);
      pat = {32'hC3A50000 + i, 32'h5A3C0000 + i};
      if (s3)
         pat[63:32] = 32'h00000000;
   endfunction : pat

   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report

   // ---------------------------------------------------------------
   // One write transfer, judged at both user sides and on the wire
   // ---------------------------------------------------------------
   task automatic run_xfer(input logic s3, input logic [7:0] x, input logic [63:0] ad,
      input logic [8:0] n);
      logic [63:0] exp_a;
      logic [31:0] pa [3];
      int k, got, ne;
      logic tk, pds, hs, dn, fin, bz, ng;
      exp_a = (x == tev_pkg::XAM_A32) ? {32'h0, ad[31:0]} : s3 ? {24'h0, ad[39:0]} : ad;
      k = 0;
      got = 0;
      ne = 0;
      tk = 0;
      hs = 0;
      dn = 0;
      fin = 0;
      bz = 0;
      ng = 0;
      pds = bus.ds;
      size_3u = s3;
      xam = x;
      addr = ad;
      beats = n;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      for (int c = 0; c < 4000 && !fin; c++)
      begin
         k += tk;
         tk = wready && k < n;
         wvalid = tk;
         wdata = pat(k, 1'b0);
         if (bus.ds !== pds)
         begin
            if (ne < 3)
               pa[ne] = bus.a;
            ne++;
            pds = bus.ds;
         end
         if (hv)
         begin
            hs = 1;
            `CHK({h3, hw, ho, hb}, {s3, x == tev_pkg::XAM_WIDE, 1'b0, n})
            `CHK(ha, exp_a)
         end
         if (dv)
         begin
            `CHK({hs, sdata}, {1'b1, pat(got, s3)})
            got++;
         end
         dn |= done;
         bz |= busy;
         ng |= ig | err;
         fin = dn && en;
         @(negedge clk);
      end
      wvalid = 1'b0;
      `CHK({fin, hs}, 2'b11)
      `CHK({bz, ng}, 2'b10)
      `CHK(ne, 3 + n)
      `CHK(got, n)
      `CHK(pa[0][7:0], x)
      `CHK(pa[1][15:8], n[8:1])
      `CHK(pa[2], ad[31:0])
   endtask : run_xfer

   task automatic test_full_size;
      run_xfer(1'b0, tev_pkg::XAM_WIDE, 64'h0123456789ABC800, 9'h100);
      run_xfer(1'b0, tev_pkg::XAM_A32, 64'h00000000000007E0, 9'h004);
      $display("test full size done");
   endtask : test_full_size

   task automatic test_small_format;
      run_xfer(1'b1, tev_pkg::XAM_WIDE, 64'h00000012345673F8, 9'h002);
      run_xfer(1'b1, tev_pkg::XAM_A32, 64'h0000000000001000, 9'h000);
      $display("test small format done");
   endtask : test_small_format

   task automatic bad_req(input logic s3, input logic [7:0] x, input logic [63:0] ad,
      input logic [8:0] n);
      logic e;
      e = 0;
      size_3u = s3;
      xam = x;
      addr = ad;
      beats = n;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      repeat (3)
      begin
         e |= err;
         `CHK(bus.as_n, 1'b1)
         @(negedge clk);
      end
      `CHK(e, 1'b1)
   endtask : bad_req

   task automatic test_refused;
      bad_req(1'b0, tev_pkg::XAM_WIDE, 64'h00000000000007F8, 9'h002);
      bad_req(1'b1, tev_pkg::XAM_A32, 64'h00000000000003FC, 9'h002);
      bad_req(1'b0, tev_pkg::XAM_A32, 64'h0000000000000000, 9'h003);
      bad_req(1'b0, 8'h03, 64'h0000000000000000, 9'h002);
      bad_req(1'b0, tev_pkg::XAM_A32, 64'h0000000000000000, 9'h102);
      $display("test refused done");
   endtask : test_refused

   task automatic drive_b(input logic [5:0] m, input logic [7:0] x, input logic bad);
      logic seen;
      logic dt0;
      seen = 0;
      dt0 = bus_b.dtack;
      bus_b.am = m;
      bus_b.a = {24'h000000, x};
      bus_b.as_n = 1'b0;
      @(negedge clk);
      bus_b.ds = ~bus_b.ds;
      repeat (8)
      begin
         @(negedge clk);
         seen |= ig_b;
      end
      `CHK({seen, bus_b.dtack}, {bad, bad ? dt0 : ~dt0})
      bus_b.as_n = 1'b1;
      bus_b.a = ~bus_b.a;
      repeat (2) @(negedge clk);
   endtask : drive_b

   task automatic test_ignore;
      drive_b(tev_pkg::AM_6U, 8'h00, 1'b1);
      drive_b(tev_pkg::AM_3U, 8'h03, 1'b1);
      drive_b(6'h22, tev_pkg::XAM_A32, 1'b1);
      drive_b(tev_pkg::AM_6U, 8'hFF, 1'b1);
      drive_b(tev_pkg::AM_3U, tev_pkg::XAM_WIDE, 1'b1);
      drive_b(tev_pkg::AM_6U, tev_pkg::XAM_WIDE, 1'b0);
      $display("test ignore done");
   endtask : test_ignore

   // A full header whose count field says the length is unknown.
   task automatic test_open;
      logic op;
      op = 0;
      bus_b.am = tev_pkg::AM_6U;
      bus_b.a = {24'h000000, tev_pkg::XAM_A32};
      bus_b.as_n = 1'b0;
      for (int p = 0; p < 3; p++)
      begin
         @(negedge clk);
         bus_b.ds = ~bus_b.ds;
         repeat (8)
         begin
            @(negedge clk);
            op |= hv_b;
         end
         bus_b.a = (p == 0) ? {16'h0000, tev_pkg::BCNT_UNKNOWN, 8'h00} : 32'h0000_4000;
      end
      `CHK({op, ho_b, hb_b}, {1'b1, 1'b1, 9'h000})
      bus_b.as_n = 1'b1;
      bus_b.a = ~bus_b.a;
      repeat (4) @(negedge clk);
      $display("test open count done");
   endtask : test_open

   initial
   begin
      rst = 1'b1;
      start = 1'b0;
      size_3u = 1'b0;
      xam = 8'h00;
      addr = 64'h0;
      beats = 9'h000;
      wdata = 64'h0;
      wvalid = 1'b0;
      bus_b.as_n = 1'b1;
      bus_b.ds = 1'b0;
      bus_b.am = 6'h00;
      bus_b.a = 32'h0;
      bus_b.d = 64'h0;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      test_full_size();
      test_small_format();
      test_refused();
      test_ignore();
      test_open();
      final_report();
   end

   initial
   begin
      #200000;
      num_errors++;
      final_report();
   end
endmodule : test_two_edge_vme_address_phase
`default_nettype wire

// ---- verif/tev_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module tev_asserts (
   input wire logic clk,
   input wire logic rst,
   input wire logic as_n,
   input wire logic ds,
   input wire logic dtack,
   input wire logic [5:0] am,
   input wire logic [31:0] a,
   input wire logic [63:0] d
);
   // ---------------------------------------------------------------
   // Strobe edge count and pending acknowledge
   // ---------------------------------------------------------------
   logic [9:0] edg_q;
   logic pend_q;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         edg_q <= 10'h000;
      else if (as_n)
         edg_q <= 10'h000;
      else if ($changed(ds))
         edg_q <= edg_q + 10'h001;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pend_q <= 1'b0;
      else if ($changed(ds))
         pend_q <= 1'b1;
      else if ($changed(dtack))
         pend_q <= 1'b0;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_ack_after_strobe: assert property (
      $changed(ds) |-> ##3 $changed(dtack)) else $error("acknowledge not three cycles after strobe");
   chk_strobe_gap: assert property (
      $changed(ds) |=> !$changed(ds) [*6]) else $error("strobe edges closer than seven cycles");
   chk_first_strobe: assert property (
      $fell(as_n) |-> ##1 $changed(ds)) else $error("first phase strobe late");
   chk_lines_stable: assert property (
      pend_q && !$changed(dtack) |-> $stable(a) && $stable(d)) else $error("lines moved before ack");
   chk_hold_select: assert property (
      pend_q |-> !as_n) else $error("address strobe released with ack pending");
   chk_modifier_code: assert property (
      !as_n |-> am == tev_pkg::AM_6U || am == tev_pkg::AM_3U) else $error("bad modifier");
   chk_ext_code: assert property (
      $fell(as_n) |-> a[7:0] == tev_pkg::XAM_A32 || a[7:0] == tev_pkg::XAM_WIDE)
      else $error("bad extended code");
   chk_small_phase_one: assert property (
      $fell(as_n) && am == tev_pkg::AM_3U |-> a[31:8] == 24'h000000)
      else $error("small format first phase upper lines not zero");
   chk_phase_two: assert property (
      $changed(ds) && edg_q == 10'h001 |-> a[7:0] == 8'h00 && a[31:24] == 8'h00
      && a[15:8] <= tev_pkg::BCNT_MAX) else $error("second phase layout wrong");
   chk_small_data: assert property (
      !as_n && am == tev_pkg::AM_3U |-> d[63:32] == 32'h00000000)
      else $error("small format upper data not zero");
   chk_idle_zero: assert property (
      as_n |-> a == 32'h00000000 && d == 64'h0000000000000000) else $error("idle lines not zero");
endmodule : tev_asserts
`default_nettype wire
